// ===== byte_fifo.sv
`timescale 1ns/10ps
module byte_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic flush,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);
	logic [W-1:0] mem_q [DEPTH];
	logic [PW-1:0] wr_q, rd_q;
	logic [PW:0] cnt_q;
	logic push, pop;

	assign in_ready = (cnt_q != (PW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data = mem_q[rd_q];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else if (flush) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == PW'(DEPTH-1)) ? '0 : wr_q + PW'(1);
			end
			if (pop) begin
				rd_q <= (rd_q == PW'(DEPTH-1)) ? '0 : rd_q + PW'(1);
			end
			cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
		end
	end
endmodule

// ===== flash_cmd_engine.sv
// What this block does
// - Fast read: command, 24 address bits, dummy byte in; data out on falling edges.
// - Fast and two-lane reads step the address per byte and wrap past the top to zero.
// - Chip select high ends a read at any time; outputs stop driving at once.
// - Stream, lock and one-time reads are ignored while a cycle is busy.
// - Two-lane read has the same header; data leave on both lanes, two bits per clock.
// - Lock read: command and sector address, no dummy; lock byte shifted out.
// - Lock byte: bits 7-2 read zero, bit 1 lock-down, bit 0 write-lock.
// - A set lock-down flag freezes both flags of that sector until reset.
// - A write-locked sector refuses page programming and stays unchanged.
// - One-time read: command, address, dummy; only low seven address bits count.
// - One-time read steps without wrap; after byte 65 it repeats that byte.
// - Page program runs only if the write unlock latch was set before.
// - Page program frame: command, three address bytes, one or more data bytes.
// - Data past the page end wraps to that page's first byte.
// - Only the last 256 bytes are kept; unwritten page bytes stay untouched.
// - Page program with chip select rising off a byte boundary is dropped.
// - Accepted page program starts a self-timed cycle; busy flag shows it.
// - The write unlock latch clears when the program cycle starts.
// - Pages inside the block guard region are never programmed.
`timescale 1ns/10ps
module flash_cmd_engine #(
	parameter int SECTORS = 128,
	parameter int SECT_W = 7,
	parameter int FIFO_DEPTH = 8
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Serial link pins
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic serial_lane_in,
	output logic serial_lane_in_o,
	output logic serial_lane_in_oe,
	output logic serial_lane_out,
	output logic serial_lane_out_oe,
	// Array read port
	output logic arr_rd_valid,
	input wire logic arr_rd_ready,
	output flash_seq_pkg::rd_req_t arr_rd_req,
	input wire logic arr_rsp_valid,
	output logic arr_rsp_ready,
	input wire logic [7:0] arr_rsp_data,
	// Array program port
	output logic prog_valid,
	input wire logic prog_ready,
	output flash_seq_pkg::prog_req_t prog_req,
	// Status
	input wire logic busy_ext,
	input wire logic [2:0] block_guard_bits,
	output logic busy_flag,
	output logic write_unlock_latch,
	// Lock byte updates
	input wire logic lock_wr_valid,
	input wire logic [SECT_W-1:0] lock_wr_sector,
	input wire logic [1:0] lock_wr_bits
);
	localparam int AW = flash_seq_pkg::ADDR_W;
	localparam int PW = flash_seq_pkg::PAGE_IDX_W;

	logic sclk_s, cs_n_s, cs_sel_s, din_s, sclk_prev_q, cs_prev_q;
	logic rise, fall, cs_up;
	flash_seq_pkg::phase_t st_q, st_after_cmd;
	logic [4:0] cnt_q;
	logic [7:0] op_q, op_next;
	logic [AW-1:0] addr_q, addr_next;
	logic dual_q, stream_op, header_done;
	logic pf_on_q, outst_q, stale_q, pf_fire, rsp_take;
	logic [AW-1:0] pf_addr_q;
	logic fifo_in_ready, fifo_out_valid;
	logic [7:0] fifo_out_data;
	logic [2:0] out_left_q;
	logic [7:0] out_sr_q, load_byte;
	logic load_now;
	logic [6:0] din_sr_q;
	logic [PW-1:0] wr_idx_q, prog_idx_q;
	logic [AW-PW-1:0] page_q;
	logic [7:0] page_buf_q [2**PW];
	logic [2**PW-1:0] fill_mask_q;
	logic got_byte_q, pp_ok, prog_busy_q, wel_q;
	logic [1:0] lock_q [SECTORS];
	logic [SECT_W-1:0] page_sect, rd_sect;
	logic [SECT_W:0] guard_span;
	logic guarded;

	pin_sync #(.W(3)) u_sync (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.async_in({sclk, ~cs_n, serial_lane_in}),
		.sync_out({sclk_s, cs_sel_s, din_s})
	);
	// Synced in its active sense so the flop reset value means deselected: no false edge
	assign cs_n_s = ~cs_sel_s;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sclk_prev_q <= 1'b0;
			cs_prev_q <= 1'b1;
		end else begin
			sclk_prev_q <= sclk_s;
			cs_prev_q <= cs_n_s;
		end
	end

	assign rise = sclk_s & ~sclk_prev_q & ~cs_n_s;
	assign fall = ~sclk_s & sclk_prev_q & ~cs_n_s;
	assign cs_up = cs_n_s & ~cs_prev_q;
	assign busy_flag = prog_busy_q | busy_ext;
	assign write_unlock_latch = wel_q;

	assign op_next = {op_q[6:0], din_s};
	assign addr_next = {addr_q[AW-2:0], din_s};
	assign header_done = rise & (st_q == flash_seq_pkg::PH_ADDR)
		& (cnt_q == flash_seq_pkg::CNT_ADDR_LAST);
	assign stream_op = (op_q == flash_seq_pkg::OP_FAST_READ)
		| (op_q == flash_seq_pkg::OP_TWO_LANE_READ) | (op_q == flash_seq_pkg::OP_ONETIME_READ);

	// Decode the command byte into the next phase
	always_comb begin
		unique case (op_next)
			flash_seq_pkg::OP_FAST_READ,
			flash_seq_pkg::OP_TWO_LANE_READ,
			flash_seq_pkg::OP_ONETIME_READ,
			flash_seq_pkg::OP_SECTOR_LOCK_READ,
			flash_seq_pkg::OP_PAGE_WRITE: begin
				st_after_cmd = busy_flag ? flash_seq_pkg::PH_SKIP : flash_seq_pkg::PH_ADDR;
			end
			flash_seq_pkg::OP_STATUS_READ: begin
				st_after_cmd = flash_seq_pkg::PH_DOUT;
			end
			default: begin
				st_after_cmd = flash_seq_pkg::PH_SKIP;
			end
		endcase
	end

	// Frame phase; deselect always returns to the command phase
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= flash_seq_pkg::PH_CMD;
			cnt_q <= '0;
			op_q <= '0;
			addr_q <= '0;
		end else if (cs_n_s) begin
			st_q <= flash_seq_pkg::PH_CMD;
			cnt_q <= '0;
		end else if (rise) begin
			unique case (st_q)
				flash_seq_pkg::PH_CMD: begin
					op_q <= op_next;
					cnt_q <= (cnt_q == flash_seq_pkg::CNT_BYTE_LAST) ? '0 : cnt_q + 5'h01;
					if (cnt_q == flash_seq_pkg::CNT_BYTE_LAST) begin
						st_q <= st_after_cmd;
					end
				end
				flash_seq_pkg::PH_ADDR: begin
					addr_q <= addr_next;
					cnt_q <= (cnt_q == flash_seq_pkg::CNT_ADDR_LAST) ? '0 : cnt_q + 5'h01;
					if (cnt_q == flash_seq_pkg::CNT_ADDR_LAST) begin
						if (op_q == flash_seq_pkg::OP_SECTOR_LOCK_READ) begin
							st_q <= flash_seq_pkg::PH_DOUT;
						end else if (op_q == flash_seq_pkg::OP_PAGE_WRITE) begin
							st_q <= flash_seq_pkg::PH_DIN;
						end else begin
							st_q <= flash_seq_pkg::PH_DUMMY;
						end
					end
				end
				flash_seq_pkg::PH_DUMMY: begin
					cnt_q <= (cnt_q == flash_seq_pkg::CNT_BYTE_LAST) ? '0 : cnt_q + 5'h01;
					if (cnt_q == flash_seq_pkg::CNT_BYTE_LAST) begin
						st_q <= flash_seq_pkg::PH_DOUT;
					end
				end
				flash_seq_pkg::PH_DIN: begin
					cnt_q <= (cnt_q == flash_seq_pkg::CNT_BYTE_LAST) ? '0 : cnt_q + 5'h01;
				end
				flash_seq_pkg::PH_SKIP: begin
					// Any extra bit spoils a one-byte command
					cnt_q <= 5'h01;
				end
				flash_seq_pkg::PH_DOUT: begin
					cnt_q <= cnt_q;
				end
			endcase
		end
	end

	// Prefetch for stream reads; one request outstanding at a time
	assign arr_rd_valid = pf_on_q & ~outst_q & ~cs_n_s;
	assign arr_rd_req.otp = (op_q == flash_seq_pkg::OP_ONETIME_READ);
	assign arr_rd_req.addr = pf_addr_q;
	assign pf_fire = arr_rd_valid & arr_rd_ready;
	assign arr_rsp_ready = stale_q | fifo_in_ready;
	assign rsp_take = arr_rsp_valid & arr_rsp_ready;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pf_on_q <= 1'b0;
			pf_addr_q <= '0;
			dual_q <= 1'b0;
		end else if (cs_n_s) begin
			pf_on_q <= 1'b0;
			dual_q <= 1'b0;
		end else if (header_done & stream_op) begin
			pf_on_q <= 1'b1;
			dual_q <= (op_q == flash_seq_pkg::OP_TWO_LANE_READ);
			if (op_q == flash_seq_pkg::OP_ONETIME_READ) begin
				pf_addr_q <= AW'(addr_next[flash_seq_pkg::OTP_IDX_W-1:0]);
			end else begin
				pf_addr_q <= addr_next;
			end
		end else if (pf_fire) begin
			if (arr_rd_req.otp) begin
				if (pf_addr_q[flash_seq_pkg::OTP_IDX_W-1:0] < flash_seq_pkg::OTP_LAST_IDX) begin
					pf_addr_q <= pf_addr_q + AW'(1);
				end
			end else begin
				pf_addr_q <= pf_addr_q + AW'(1);
			end
		end
	end

	// A reply still in flight at deselect belongs to the old frame
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			outst_q <= 1'b0;
			stale_q <= 1'b0;
		end else begin
			if (pf_fire) begin
				outst_q <= 1'b1;
			end else if (rsp_take) begin
				outst_q <= 1'b0;
			end
			if (rsp_take) begin
				stale_q <= 1'b0;
			end else if (cs_up & outst_q) begin
				stale_q <= 1'b1;
			end
		end
	end

	byte_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_fifo (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.flush(cs_n_s),
		.in_valid(arr_rsp_valid & ~stale_q),
		.in_ready(fifo_in_ready),
		.in_data(arr_rsp_data),
		.out_valid(fifo_out_valid),
		.out_ready(load_now & stream_op),
		.out_data(fifo_out_data)
	);

	assign rd_sect = addr_q[flash_seq_pkg::SECT_LSB +: SECT_W];
	assign load_now = fall & (st_q == flash_seq_pkg::PH_DOUT) & (out_left_q == '0);

	always_comb begin
		load_byte = '0;
		if (op_q == flash_seq_pkg::OP_SECTOR_LOCK_READ) begin
			load_byte[1:0] = lock_q[rd_sect];
		end else if (op_q == flash_seq_pkg::OP_STATUS_READ) begin
			load_byte[flash_seq_pkg::ST_BUSY_BIT] = busy_flag;
			load_byte[flash_seq_pkg::ST_WEL_BIT] = wel_q;
			load_byte[flash_seq_pkg::ST_GUARD_LSB +: 3] = block_guard_bits;
		end else if (fifo_out_valid) begin
			load_byte = fifo_out_data;
		end
	end

	// Output shifter; lanes change only on falling link clock edges
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			out_left_q <= '0;
			out_sr_q <= '0;
			serial_lane_out <= 1'b0;
			serial_lane_in_o <= 1'b0;
		end else if (cs_n_s) begin
			out_left_q <= '0;
		end else if (load_now) begin
			serial_lane_out <= load_byte[7];
			serial_lane_in_o <= load_byte[6];
			out_sr_q <= dual_q ? {load_byte[5:0], 2'b00} : {load_byte[6:0], 1'b0};
			out_left_q <= dual_q ? flash_seq_pkg::OUT_LEFT_DUAL : flash_seq_pkg::OUT_LEFT_SINGLE;
		end else if (fall & (st_q == flash_seq_pkg::PH_DOUT)) begin
			serial_lane_out <= out_sr_q[7];
			serial_lane_in_o <= out_sr_q[6];
			out_sr_q <= dual_q ? {out_sr_q[5:0], 2'b00} : {out_sr_q[6:0], 1'b0};
			out_left_q <= out_left_q - 3'h1;
		end
	end

	// Drive is gated by the synced select so it drops as soon as it is seen
	assign serial_lane_out_oe = (st_q == flash_seq_pkg::PH_DOUT) & ~cs_n_s;
	assign serial_lane_in_oe = serial_lane_out_oe & dual_q;

	// Page buffer: the index wraps inside the page, so later bytes overwrite
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			din_sr_q <= '0;
			wr_idx_q <= '0;
			page_q <= '0;
			fill_mask_q <= '0;
			got_byte_q <= 1'b0;
		end else if (header_done & (op_q == flash_seq_pkg::OP_PAGE_WRITE)) begin
			wr_idx_q <= addr_next[PW-1:0];
			page_q <= addr_next[AW-1:PW];
			fill_mask_q <= '0;
			got_byte_q <= 1'b0;
		end else if (rise & (st_q == flash_seq_pkg::PH_DIN)) begin
			din_sr_q <= {din_sr_q[5:0], din_s};
			if (cnt_q == flash_seq_pkg::CNT_BYTE_LAST) begin
				fill_mask_q[wr_idx_q] <= 1'b1;
				wr_idx_q <= wr_idx_q + PW'(1);
				got_byte_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rise & (st_q == flash_seq_pkg::PH_DIN) & (cnt_q == flash_seq_pkg::CNT_BYTE_LAST)) begin
			page_buf_q[wr_idx_q] <= {din_sr_q, din_s};
		end
	end

	// Block guard: top region of 2^(bits-1) sectors
	assign page_sect = page_q[flash_seq_pkg::SECT_LSB-PW +: SECT_W];
	assign guard_span = (SECT_W+1)'(1) << (block_guard_bits - 3'h1);
	assign guarded = (block_guard_bits != 3'h0)
		& ({1'b0, page_sect} >= ((SECT_W+1)'(SECTORS) - guard_span));

	assign pp_ok = cs_up & (op_q == flash_seq_pkg::OP_PAGE_WRITE) & (st_q == flash_seq_pkg::PH_DIN)
		& (cnt_q == '0) & got_byte_q
		& wel_q & ~busy_flag & ~guarded
		& ~lock_q[page_sect][flash_seq_pkg::WRITE_LOCK_BIT];

	// Write unlock latch
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wel_q <= 1'b0;
		end else if (pp_ok) begin
			wel_q <= 1'b0;
		end else if (cs_up & (op_q == flash_seq_pkg::OP_WRITE_UNLOCK)
			& (st_q == flash_seq_pkg::PH_SKIP) & (cnt_q == '0)) begin
			wel_q <= 1'b1;
		end
	end

	// Self-timed program cycle: walk the page, hand over each filled byte
	assign prog_valid = prog_busy_q & fill_mask_q[prog_idx_q];
	assign prog_req.addr = {page_q, prog_idx_q};
	assign prog_req.data = page_buf_q[prog_idx_q];

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			prog_busy_q <= 1'b0;
			prog_idx_q <= '0;
		end else if (pp_ok) begin
			prog_busy_q <= 1'b1;
			prog_idx_q <= '0;
		end else if (prog_busy_q & (prog_ready | ~fill_mask_q[prog_idx_q])) begin
			prog_idx_q <= prog_idx_q + PW'(1);
			if (prog_idx_q == {PW{1'b1}}) begin
				prog_busy_q <= 1'b0;
			end
		end
	end

	// Sector lock flags, frozen once lock-down is set
	for (genvar s = 0; s < SECTORS; s++) begin : g_lock
		always_ff @(posedge ref_clk or negedge rst_n) begin
			if (!rst_n) begin
				lock_q[s] <= flash_seq_pkg::LOCK_RESET;
			end else if (lock_wr_valid & (lock_wr_sector == SECT_W'(s))
				& ~lock_q[s][flash_seq_pkg::LOCK_DOWN_BIT]) begin
				lock_q[s] <= lock_wr_bits;
			end
		end
	end
endmodule

// ===== flash_cmd_engine_asserts.sv
`timescale 1ns/10ps
module flash_cmd_engine_asserts (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Watched ports
	input wire logic cs_n,
	input wire logic serial_lane_in_oe,
	input wire logic serial_lane_out_oe,
	input wire logic arr_rd_valid,
	input wire flash_seq_pkg::rd_req_t arr_rd_req,
	input wire logic prog_valid,
	input wire logic prog_ready,
	input wire flash_seq_pkg::prog_req_t prog_req,
	input wire logic busy_ext,
	input wire logic busy_flag,
	input wire logic write_unlock_latch
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);
	// Long enough for the two-stage sync to have seen the deselect
	sequence s_deselected;
		cs_n [*4];
	endsequence
	sequence s_prog_stall;
		prog_valid && !prog_ready;
	endsequence
	property p_oe_off_after_cs;
		s_deselected |-> !serial_lane_out_oe && !serial_lane_in_oe;
	endproperty
	a_oe_off_after_cs: assert property (p_oe_off_after_cs)
		else $error("lane still driven after deselect");
	property p_dual_both;
		serial_lane_in_oe |-> serial_lane_out_oe;
	endproperty
	a_dual_both: assert property (p_dual_both)
		else $error("in lane driven without out lane");
	property p_busy_ext;
		busy_ext |-> busy_flag;
	endproperty
	a_busy_ext: assert property (p_busy_ext)
		else $error("busy flag low while other cycle runs");
	property p_prog_busy;
		prog_valid |-> busy_flag && !write_unlock_latch;
	endproperty
	a_prog_busy: assert property (p_prog_busy)
		else $error("program beat without busy or with latch set");
	property p_prog_hold;
		s_prog_stall |=> prog_valid && $stable(prog_req);
	endproperty
	a_prog_hold: assert property (p_prog_hold)
		else $error("program beat changed while stalled");
	property p_same_page;
		prog_valid ##1 prog_valid |-> prog_req.addr[23:8] == $past(prog_req.addr[23:8]);
	endproperty
	a_same_page: assert property (p_same_page)
		else $error("program left its page");
	property p_otp_range;
		arr_rd_valid && arr_rd_req.otp |-> arr_rd_req.addr <= 24'h00_0040;
	endproperty
	a_otp_range: assert property (p_otp_range)
		else $error("one-time index past last byte");
	property p_no_read_busy;
		$rose(arr_rd_valid) |-> !busy_flag;
	endproperty
	a_no_read_busy: assert property (p_no_read_busy)
		else $error("array read started while busy");
endmodule

bind flash_cmd_engine flash_cmd_engine_asserts chk_u (.ref_clk(ref_clk), .rst_n(rst_n),
	.cs_n(cs_n), .serial_lane_in_oe(serial_lane_in_oe), .serial_lane_out_oe(serial_lane_out_oe),
	.arr_rd_valid(arr_rd_valid), .arr_rd_req(arr_rd_req), .prog_valid(prog_valid),
	.prog_ready(prog_ready), .prog_req(prog_req), .busy_ext(busy_ext), .busy_flag(busy_flag),
	.write_unlock_latch(write_unlock_latch));

// ===== flash_seq_pkg.sv
package flash_seq_pkg;

	localparam int ADDR_W = 24;
	localparam int PAGE_IDX_W = 8;
	localparam int SECT_LSB = 16;

	// Command codes of this part
	localparam logic [7:0] OP_FAST_READ = 8'h0b;
	localparam logic [7:0] OP_TWO_LANE_READ = 8'h3b;
	localparam logic [7:0] OP_SECTOR_LOCK_READ = 8'he8;
	localparam logic [7:0] OP_ONETIME_READ = 8'h4b;
	localparam logic [7:0] OP_PAGE_WRITE = 8'h02;
	localparam logic [7:0] OP_WRITE_UNLOCK = 8'h06;
	localparam logic [7:0] OP_STATUS_READ = 8'h05;

	// Bit counts, counted from zero
	localparam logic [4:0] CNT_BYTE_LAST = 5'h07;
	localparam logic [4:0] CNT_ADDR_LAST = 5'h17;
	localparam logic [2:0] OUT_LEFT_SINGLE = 3'h7;
	localparam logic [2:0] OUT_LEFT_DUAL = 3'h3;

	// One-time area: 65 bytes, index 64 is the last
	localparam int OTP_IDX_W = 7;
	localparam logic [6:0] OTP_LAST_IDX = 7'h40;

	// Sector lock byte layout
	localparam int LOCK_DOWN_BIT = 1;
	localparam int WRITE_LOCK_BIT = 0;
	localparam logic [1:0] LOCK_RESET = 2'h0;

	// Status byte layout
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_WEL_BIT = 1;
	localparam int ST_GUARD_LSB = 2;

	typedef enum logic [2:0] {
		PH_CMD = 3'b000,
		PH_ADDR = 3'b001,
		PH_DUMMY = 3'b011,
		PH_DOUT = 3'b010,
		PH_DIN = 3'b110,
		PH_SKIP = 3'b111
	} phase_t;

	typedef struct packed {
		logic otp;
		logic [ADDR_W-1:0] addr;
	} rd_req_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [7:0] data;
	} prog_req_t;

endpackage

// ===== pin_sync.sv
`timescale 1ns/10ps
module pin_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Levels
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta_q;

	// First stage is read by the second stage only
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= '0;
			sync_out <= '0;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule

// ===== spi_host_model.sv
`timescale 1ns/10ps
module spi_host_model (
	// Clock
	input wire logic ref_clk,
	// Link pins
	output logic sclk,
	output logic cs_n,
	output logic host_d,
	input wire logic lane_in_w,
	input wire logic lane_out
);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		host_d = 1'b0;
	end
	// Low 5 cycles, high 3: device output has settled before the rise
	task automatic bit_cycle(input logic d, output logic q_out, output logic q_in);
		@(negedge ref_clk);
		sclk = 1'b0;
		host_d = d;
		repeat (5) @(negedge ref_clk);
		q_out = lane_out;
		q_in = lane_in_w;
		sclk = 1'b1;
		repeat (2) @(negedge ref_clk);
	endtask
	task automatic start;
		@(negedge ref_clk);
		cs_n = 1'b0;
		repeat (3) @(negedge ref_clk);
	endtask
	task automatic stop;
		@(negedge ref_clk);
		sclk = 1'b0;
		repeat (3) @(negedge ref_clk);
		cs_n = 1'b1;
		repeat (6) @(negedge ref_clk);
	endtask
	task automatic send(input logic [31:0] v, input int n);
		logic a;
		logic b;
		for (int i = n - 1; i >= 0; i--) begin
			bit_cycle(v[i], a, b);
		end
	endtask
	// Host lets go of the in lane: drive the inverse each clock, never a steady value
	task automatic recv(input bit dual, output logic [7:0] r);
		logic spare;
		for (int i = 7; i >= 0; i -= (dual ? 2 : 1)) begin
			if (dual) begin
				bit_cycle(~host_d, r[i], r[i - 1]);
			end else begin
				bit_cycle(~host_d, r[i], spare);
			end
		end
	endtask
endmodule

// ===== testbench.sv
`timescale 1ns/10ps
module testbench;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic sclk, cs_n, host_d, lane_in_w, lane_in_o, lane_in_oe, lane_out, lane_out_oe;
	logic arr_rd_valid, arr_rsp_ready, prog_valid, busy_flag, write_unlock_latch;
	logic arr_rsp_valid = 1'b0;
	logic [7:0] arr_rsp_data = 8'h00;
	flash_seq_pkg::rd_req_t arr_rd_req;
	flash_seq_pkg::prog_req_t prog_req;
	logic prog_ready = 1'b1;
	logic stall = 1'b0;
	logic busy_ext = 1'b0;
	logic [2:0] guard = 3'h0;
	logic lock_wr_valid = 1'b0;
	logic [6:0] lock_wr_sector = 7'h00;
	logic [1:0] lock_wr_bits = 2'h0;
	logic oe_seen = 1'b0;
	logic [7:0] mem [int];
	logic [7:0] got [$];
	logic [7:0] st_byte;
	int prog_cnt = 0;
	int failures = 0;
	int tests_run = 0;

	always #12.5 ref_clk = ~ref_clk;
	assign lane_in_w = lane_in_oe ? lane_in_o : host_d;

	flash_cmd_engine dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n),
		.serial_lane_in(lane_in_w), .serial_lane_in_o(lane_in_o),
		.serial_lane_in_oe(lane_in_oe), .serial_lane_out(lane_out),
		.serial_lane_out_oe(lane_out_oe), .arr_rd_valid(arr_rd_valid), .arr_rd_ready(1'b1),
		.arr_rd_req(arr_rd_req), .arr_rsp_valid(arr_rsp_valid), .arr_rsp_ready(arr_rsp_ready),
		.arr_rsp_data(arr_rsp_data), .prog_valid(prog_valid), .prog_ready(prog_ready),
		.prog_req(prog_req), .busy_ext(busy_ext), .block_guard_bits(guard),
		.busy_flag(busy_flag), .write_unlock_latch(write_unlock_latch),
		.lock_wr_valid(lock_wr_valid), .lock_wr_sector(lock_wr_sector),
		.lock_wr_bits(lock_wr_bits));
	spi_host_model host_u (.ref_clk(ref_clk), .sclk(sclk), .cs_n(cs_n), .host_d(host_d),
		.lane_in_w(lane_in_w), .lane_out(lane_out));

	function automatic logic [7:0] pat(input logic [23:0] a, input logic otp);
		return a[7:0] ^ a[15:8] ^ a[23:16] ^ (otp ? 8'ha5 : 8'h3c);
	endfunction
	// Array stand-in: answers one cycle after each request, programs into mem
	always_ff @(posedge ref_clk) begin
		if (arr_rd_valid) begin
			arr_rsp_valid <= 1'b1;
			arr_rsp_data <= pat(arr_rd_req.addr, arr_rd_req.otp);
		end else if (arr_rsp_ready) begin
			arr_rsp_valid <= 1'b0;
		end
	end
	always @(posedge ref_clk) begin
		if (prog_valid && prog_ready) begin
			mem[int'(prog_req.addr)] = prog_req.data;
			prog_cnt++;
		end
		if (lane_out_oe) begin
			oe_seen = 1'b1;
		end
	end
	always @(negedge ref_clk) begin
		prog_ready <= stall ? ~prog_ready : 1'b1;
	end

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic finish_test;
		$display("Checks %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic rd(input logic [7:0] op, input logic [23:0] a, input int n, input int tail);
		logic [7:0] r;
		got.delete();
		host_u.start();
		host_u.send({24'h00_0000, op}, 8);
		host_u.send({8'h00, a}, 24);
		if (op != flash_seq_pkg::OP_SECTOR_LOCK_READ) begin
			host_u.send(32'h0000_0000, 8);
		end
		for (int k = 0; k < n; k++) begin
			host_u.recv(op == flash_seq_pkg::OP_TWO_LANE_READ, r);
			got.push_back(r);
		end
		host_u.send(32'h0000_0000, tail);
		host_u.stop();
	endtask
	task automatic unlock;
		host_u.start();
		host_u.send({24'h00_0000, flash_seq_pkg::OP_WRITE_UNLOCK}, 8);
		host_u.stop();
	endtask
	task automatic pw(input logic [23:0] a, input int n, input int tail);
		host_u.start();
		host_u.send({flash_seq_pkg::OP_PAGE_WRITE, a}, 32);
		for (int k = 0; k < n; k++) begin
			host_u.send({24'h00_0000, k[7:0] ^ (k > 255 ? 8'h5a : 8'h00)}, 8);
		end
		host_u.send(32'h0000_0000, tail);
		host_u.stop();
	endtask
	task automatic wait_idle;
		int i;
		for (i = 0; i < 3000 && busy_flag !== 1'b0; i++) begin
			@(negedge ref_clk);
		end
		if (i == 3000) begin
			failures++;
			finish_test();
		end
	endtask
	task automatic lock_write(input logic [6:0] s, input logic [1:0] b);
		@(negedge ref_clk);
		lock_wr_valid = 1'b1;
		lock_wr_sector = s;
		lock_wr_bits = b;
		@(negedge ref_clk);
		lock_wr_valid = 1'b0;
	endtask
	task automatic done(input string name);
		$display("Test %s finished", name);
	endtask

	initial begin
		repeat (20) @(negedge ref_clk);
		rst_n = 1'b1;
		repeat (4) @(negedge ref_clk);
		rd(flash_seq_pkg::OP_FAST_READ, 24'hff_fffe, 3, 3);
		check("fr0", got[0], pat(24'hff_fffe, 1'b0));
		check("fr1", got[1], pat(24'hff_ffff, 1'b0));
		check("fr2", got[2], pat(24'h00_0000, 1'b0));
		check("oe_off", {6'h00, lane_out_oe, lane_in_oe}, 8'h00);
		done("fast_read");
		rd(flash_seq_pkg::OP_TWO_LANE_READ, 24'h00_0100, 2, 0);
		check("dual0", got[0], pat(24'h00_0100, 1'b0));
		check("dual1", got[1], pat(24'h00_0101, 1'b0));
		done("two_lane");
		rd(flash_seq_pkg::OP_ONETIME_READ, 24'hff_ffbf, 4, 0);
		check("otp0", got[0], pat(24'h00_003f, 1'b1));
		for (int k = 1; k < 4; k++) begin
			check("otp_last", got[k], pat(24'h00_0040, 1'b1));
		end
		done("onetime");
		rd(flash_seq_pkg::OP_SECTOR_LOCK_READ, 24'h06_0000, 1, 0);
		check("lock_rst", got[0], 8'h00);
		lock_write(7'h05, 2'h1);
		rd(flash_seq_pkg::OP_SECTOR_LOCK_READ, 24'h05_1234, 1, 0);
		check("lock_wl", got[0], 8'h01);
		lock_write(7'h05, 2'h3);
		lock_write(7'h05, 2'h0);
		rd(flash_seq_pkg::OP_SECTOR_LOCK_READ, 24'h05_ffff, 1, 0);
		check("lock_frozen", got[0], 8'h03);
		done("lock");
		pw(24'h00_0010, 1, 0);
		check("no_unlock_busy", {7'h00, busy_flag}, 8'h00);
		unlock();
		check("latch_set", {7'h00, write_unlock_latch}, 8'h01);
		pw(24'h00_00fe, 3, 0);
		check("busy_run", {7'h00, busy_flag}, 8'h01);
		check("latch_clr", {7'h00, write_unlock_latch}, 8'h00);
		host_u.start();
		host_u.send({24'h00_0000, flash_seq_pkg::OP_STATUS_READ}, 8);
		host_u.recv(1'b0, st_byte);
		host_u.stop();
		check("status_busy", st_byte, 8'h01);
		wait_idle();
		check("wrap_fe", mem[32'h0000_00fe], 8'h00);
		check("wrap_ff", mem[32'h0000_00ff], 8'h01);
		check("wrap_00", mem[32'h0000_0000], 8'h02);
		check("cnt3", prog_cnt[7:0], 8'h03);
		done("page_wrap");
		unlock();
		pw(24'h00_0020, 1, 3);
		unlock();
		pw(24'h05_0000, 1, 0);
		guard = 3'h1;
		unlock();
		pw(24'h7f_0000, 1, 0);
		guard = 3'h0;
		repeat (20) @(negedge ref_clk);
		check("dropped", prog_cnt[7:0], 8'h03);
		done("refusals");
		busy_ext = 1'b1;
		oe_seen = 1'b0;
		rd(flash_seq_pkg::OP_FAST_READ, 24'h00_0000, 1, 0);
		check("busy_read", {7'h00, oe_seen}, 8'h00);
		busy_ext = 1'b0;
		done("busy_reject");
		stall = 1'b1;
		unlock();
		pw(24'h00_0200, 258, 0);
		wait_idle();
		stall = 1'b0;
		check("last0", mem[32'h0000_0200], 8'h5a);
		check("last1", mem[32'h0000_0201], 8'h5b);
		check("last2", mem[32'h0000_0202], 8'h02);
		check("cnt259", prog_cnt[7:0], 8'h03);
		done("long_page");
		finish_test();
	end
endmodule
